// >>> src/smd_cfg.svh
// Purpose: offsets, field positions, reset values and codes for the dma control block
// Assumes: byte offsets within the operations register space, 12 address bits
// Notes:   definitions only
`ifndef SMD_CFG_SVH
`define SMD_CFG_SVH
// register offsets
`define SMD_OFS_LOCAL_START   12'h4b0
`define SMD_OFS_HOST_START    12'h4b4
`define SMD_OFS_LENGTH        12'h4b8
`define SMD_OFS_COMMAND       12'h4bc
`define SMD_OFS_SEMAPHORE     12'h4c0
`define SMD_OFS_HOST_RESET    12'h4e0
// field positions
`define SMD_CMD_DIR_BIT       0
`define SMD_CMD_PI_BIT        1
`define SMD_CMD_PCI_OWN_BIT   8
`define SMD_CMD_LOC_OWN_BIT   9
`define SMD_HRC_LRST_BIT      0
`define SMD_HRC_SOFT_BIT      1
`define SMD_ADDR_HI           13
`define SMD_ADDR_LO           2
// reset values
`define SMD_RST_WORD          32'h0000_0000
`define SMD_RST_HRC           1'h1
// pci command codes
`define SMD_PCI_MEM_READ      4'h6
`define SMD_PCI_MEM_WRITE     4'h7
`define SMD_PCI_READ_LINE     4'hc
`define SMD_PCI_READ_MULT     4'he
// cache line size in dwords, used to pick the read command
`define SMD_LINE_DWORDS       12'h008
`endif

// >>> src/smd_pkg.sv
// Purpose: types shared by the dma control block and its bench
// Assumes: constants live in smd_cfg.svh
// Notes:   nothing here holds a number of the register map
package smd_pkg;
	// one register access from either the local bus or the pci target side
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} smd_reg_req_t;

	// one dword move handed to the pci master and shared memory
	typedef struct packed {
		logic        dir;
		logic [3:0]  cmd;
		logic [31:0] host_addr;
		logic [13:0] local_addr;
		logic        last;
	} smd_xfer_t;

	typedef enum logic [0:0] {
		SMD_IDLE,
		SMD_MOVE
	} smd_state_t;
endpackage

// >>> src/smd_dma_ctrl.sv
// Purpose: dma setup registers, ownership flags, reset control and dword sequencer
// Assumes: both register ports and all handshakes are on core_clk
// Notes:   pci master timing, fifos and interrupt registers live elsewhere
`include "smd_cfg.svh"

// How it works
// - local start address held in bits 13:2
// - host start address, dword aligned, 32 bits
// - transfer length from length bits 13:2
// - command low byte write launches transfer
// - command bit 0 selects direction, resets 0
// - prefetch inhibit forces plain memory read
// - otherwise pick read, line or multiple
// - local owner changes by local write only
// - pci owner changes by pci write only
// - semaphore local bits need pci partner clear
// - semaphore pci bits need local partner clear
// - host control bit 1 drives soft reset
// - host control bit 0 drives reset outputs
// - chip reset sets local reset bit
// - local bus may clear it when allowed
// - soft reset returns registers to defaults
// - soft reset keeps owners, direction and host control word
// - soft reset spares interrupt regs, clears mailbox
// - soft reset floats data, idles machines
// - soft reset empties queues to empty flags
module smd_dma_ctrl (
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	input  wire logic                 ce,
	input  wire smd_pkg::smd_reg_req_t loc_req,
	output logic [31:0]               loc_rdata,
	output logic                      loc_rvalid,
	output logic                      loc_dq_oe,
	input  wire smd_pkg::smd_reg_req_t pci_req,
	output logic [31:0]               pci_rdata,
	output logic                      pci_rvalid,
	input  wire logic                 auto_cfg_done,
	input  wire logic                 cfg_term_release,
	input  wire logic                 local_clear_allowed,
	output smd_pkg::smd_xfer_t        xfer,
	output logic                      xfer_valid,
	input  wire logic                 xfer_ready,
	output logic                      dma_busy,
	output logic                      dma_done,
	output logic                      soft_reset_active,
	output logic                      mailbox_clear,
	output logic                      queue_flush,
	output logic                      local_reset_output,
	output logic                      local_reset_output_b
);

	// ******************************************************************
	// register storage
	// ******************************************************************
	logic [11:0]         local_start;      // dword index, address bits 13:2
	logic [29:0]         host_start;       // dword index, address bits 31:2
	logic [11:0]         length;           // dword count
	logic                dir_bit;
	logic                prefetch_inhibit;
	logic                loc_own;
	logic                pci_own;
	logic [3:0]          sem_loc;
	logic [3:0]          sem_pci;
	logic                lrst_bit;
	logic                soft_bit;

	// engine state
	smd_pkg::smd_state_t state;
	logic [11:0]         remaining;
	logic [11:0]         cur_local;
	logic [29:0]         cur_host;
	logic [3:0]          cur_cmd;

	// decoded writes
	logic                loc_wr_lstart;
	logic                loc_wr_hstart;
	logic                loc_wr_len;
	logic                loc_wr_cmd;
	logic                loc_wr_sem;
	logic                loc_wr_hrc;
	logic                pci_wr_lstart;
	logic                pci_wr_hstart;
	logic                pci_wr_len;
	logic                pci_wr_cmd;
	logic                pci_wr_sem;
	logic                pci_wr_hrc;
	logic                launch;
	logic                step;
	logic                next_loc_own;
	logic [3:0]          next_sem_loc;
	logic [31:0]         lstart_word;
	logic [31:0]         hstart_word;
	logic [31:0]         len_word;

	// ******************************************************************
	// helpers
	// ******************************************************************

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// read command chosen from the dwords left; long runs earn prefetch hints
	function automatic logic [3:0] pick_cmd(input logic dir, input logic pi,
		input logic [11:0] left);
		logic [3:0] c;
		if (dir) begin
			c = `SMD_PCI_MEM_WRITE;
		end else if (pi) begin
			c = `SMD_PCI_MEM_READ;
		end else if (left > (`SMD_LINE_DWORDS << 1)) begin
			c = `SMD_PCI_READ_MULT;
		end else if (left >= `SMD_LINE_DWORDS) begin
			c = `SMD_PCI_READ_LINE;
		end else begin
			c = `SMD_PCI_MEM_READ;
		end
		return c;
	endfunction

	// ******************************************************************
	// address decode
	// ******************************************************************

	// a write with no byte enable touches nothing
	always_comb begin
		loc_wr_lstart = loc_req.wr && (loc_req.addr == `SMD_OFS_LOCAL_START);
		loc_wr_hstart = loc_req.wr && (loc_req.addr == `SMD_OFS_HOST_START);
		loc_wr_len    = loc_req.wr && (loc_req.addr == `SMD_OFS_LENGTH);
		loc_wr_cmd    = loc_req.wr && (loc_req.addr == `SMD_OFS_COMMAND);
		loc_wr_sem    = loc_req.wr && (loc_req.addr == `SMD_OFS_SEMAPHORE);
		loc_wr_hrc    = loc_req.wr && (loc_req.addr == `SMD_OFS_HOST_RESET);
		pci_wr_lstart = pci_req.wr && (pci_req.addr == `SMD_OFS_LOCAL_START);
		pci_wr_hstart = pci_req.wr && (pci_req.addr == `SMD_OFS_HOST_START);
		pci_wr_len    = pci_req.wr && (pci_req.addr == `SMD_OFS_LENGTH);
		pci_wr_cmd    = pci_req.wr && (pci_req.addr == `SMD_OFS_COMMAND);
		pci_wr_sem    = pci_req.wr && (pci_req.addr == `SMD_OFS_SEMAPHORE);
		pci_wr_hrc    = pci_req.wr && (pci_req.addr == `SMD_OFS_HOST_RESET);
	end

	// low byte of the command word from either side starts the engine
	assign launch = ((loc_wr_cmd && loc_req.be[0]) || (pci_wr_cmd && pci_req.be[0]))
		&& !soft_bit;
	assign step   = (state == smd_pkg::SMD_MOVE) && xfer_ready;

	// ******************************************************************
	// dma setup words
	// ******************************************************************

	// merged setup words; local side wins when both ports write one word
	always_comb begin
		lstart_word = loc_wr_lstart ? merge({18'h0, local_start, 2'h0}, loc_req.wdata, loc_req.be)
			: merge({18'h0, local_start, 2'h0}, pci_req.wdata, pci_req.be);
		hstart_word = loc_wr_hstart ? merge({host_start, 2'h0}, loc_req.wdata, loc_req.be)
			: merge({host_start, 2'h0}, pci_req.wdata, pci_req.be);
		len_word    = loc_wr_len ? merge({18'h0, length, 2'h0}, loc_req.wdata, loc_req.be)
			: merge({18'h0, length, 2'h0}, pci_req.wdata, pci_req.be);
	end

	// only the dword bits are kept; the rest read back as zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			local_start <= 12'h000;
			host_start  <= 30'h0000_0000;
			length      <= 12'h000;
		end else if (ce) begin
			if (soft_bit) begin
				local_start <= 12'h000;
				host_start  <= 30'h0000_0000;
				length      <= 12'h000;
			end else begin
				if (loc_wr_lstart || pci_wr_lstart) begin
					local_start <= lstart_word[`SMD_ADDR_HI:`SMD_ADDR_LO];
				end
				if (loc_wr_hstart || pci_wr_hstart) begin
					host_start <= hstart_word[31:2];
				end
				if (loc_wr_len || pci_wr_len) begin
					length <= len_word[`SMD_ADDR_HI:`SMD_ADDR_LO];
				end
			end
		end
	end

	// ******************************************************************
	// command word
	// ******************************************************************

	// direction and prefetch sit in the low byte; local side wins a tie
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_bit          <= 1'b0;
			prefetch_inhibit <= 1'b0;
		end else if (ce) begin
			if (soft_bit) begin
				prefetch_inhibit <= 1'b0;
			end else if (loc_wr_cmd && loc_req.be[0]) begin
				dir_bit          <= loc_req.wdata[`SMD_CMD_DIR_BIT];
				prefetch_inhibit <= loc_req.wdata[`SMD_CMD_PI_BIT];
			end else if (pci_wr_cmd && pci_req.be[0]) begin
				dir_bit          <= pci_req.wdata[`SMD_CMD_DIR_BIT];
				prefetch_inhibit <= pci_req.wdata[`SMD_CMD_PI_BIT];
			end
		end
	end

	// the pci owner check uses the local owner's new value, so a same-cycle
	// race can never leave both owners set
	always_comb begin
		next_loc_own = loc_own;
		if (loc_wr_cmd && loc_req.be[1] && !pci_own) begin
			next_loc_own = loc_req.wdata[`SMD_CMD_LOC_OWN_BIT];
		end
	end

	// owner flags survive soft reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			loc_own <= 1'b0;
			pci_own <= 1'b0;
		end else if (ce) begin
			loc_own <= next_loc_own;
			if (pci_wr_cmd && pci_req.be[1] && !next_loc_own) begin
				pci_own <= pci_req.wdata[`SMD_CMD_PCI_OWN_BIT];
			end
		end
	end

	// ******************************************************************
	// semaphore flags
	// ******************************************************************

	// one owner pair per byte lane, local bit one above the pci bit
	generate
		for (genvar g = 0; g < 4; g++) begin : gen_sem
			always_comb begin
				next_sem_loc[g] = sem_loc[g];
				if (loc_wr_sem && loc_req.be[g] && !sem_pci[g]) begin
					next_sem_loc[g] = loc_req.wdata[g*8+1];
				end
			end

			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					sem_loc[g] <= 1'b0;
					sem_pci[g] <= 1'b0;
				end else if (ce) begin
					if (soft_bit) begin
						sem_loc[g] <= 1'b0;
						sem_pci[g] <= 1'b0;
					end else begin
						sem_loc[g] <= next_sem_loc[g];
						if (pci_wr_sem && pci_req.be[g] && !next_sem_loc[g]) begin
							sem_pci[g] <= pci_req.wdata[g*8];
						end
					end
				end
			end
		end
	endgenerate

	// ******************************************************************
	// host reset control
	// ******************************************************************

	// local reset held until configuration finishes; soft reset leaves
	// this word alone, otherwise the soft bit could never be released
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lrst_bit <= `SMD_RST_HRC;
			soft_bit <= 1'b0;
		end else if (ce) begin
			if (pci_wr_hrc && pci_req.be[0]) begin
				soft_bit <= pci_req.wdata[`SMD_HRC_SOFT_BIT];
			end else if (loc_wr_hrc && loc_req.be[0]) begin
				soft_bit <= loc_req.wdata[`SMD_HRC_SOFT_BIT];
			end
			if (auto_cfg_done) begin
				if (pci_wr_hrc && pci_req.be[0]) begin
					lrst_bit <= pci_req.wdata[`SMD_HRC_LRST_BIT];
				end else if (loc_wr_hrc && loc_req.be[0] && local_clear_allowed) begin
					lrst_bit <= loc_req.wdata[`SMD_HRC_LRST_BIT];
				end else if (cfg_term_release) begin
					lrst_bit <= 1'b0;
				end
			end
		end
	end

	// reset pins follow the bit with no extra delay
	assign local_reset_output   = lrst_bit;
	assign local_reset_output_b = !lrst_bit;

	// other blocks clear their queues and mailbox flag from these levels
	assign soft_reset_active = soft_bit;
	assign queue_flush       = soft_bit;
	assign mailbox_clear     = soft_bit;

	// ******************************************************************
	// dword sequencer
	// ******************************************************************

	// a launch while busy is dropped; a zero length moves nothing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= smd_pkg::SMD_IDLE;
			remaining <= 12'h000;
			cur_local <= 12'h000;
			cur_host  <= 30'h0000_0000;
			cur_cmd   <= `SMD_PCI_MEM_READ;
			dma_done  <= 1'b0;
		end else if (ce) begin
			dma_done <= 1'b0;
			if (soft_bit) begin
				state <= smd_pkg::SMD_IDLE;
			end else begin
				unique case (state)
					smd_pkg::SMD_IDLE: begin
						if (launch && (length != 12'h000)) begin
							state     <= smd_pkg::SMD_MOVE;
							remaining <= length;
							cur_local <= local_start;
							cur_host  <= host_start;
							cur_cmd   <= pick_cmd(next_dir(), next_pi(), length);
						end
					end
					smd_pkg::SMD_MOVE: begin
						if (step) begin
							remaining <= remaining - 12'h001;
							cur_local <= cur_local + 12'h001;
							cur_host  <= cur_host + 30'h0000_0001;
							cur_cmd   <= pick_cmd(dir_bit, prefetch_inhibit,
								remaining - 12'h001);
							if (remaining == 12'h001) begin
								state    <= smd_pkg::SMD_IDLE;
								dma_done <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	// direction and prefetch as they stand after this cycle's write
	function automatic logic next_dir();
		logic d;
		d = dir_bit;
		if (loc_wr_cmd && loc_req.be[0]) begin
			d = loc_req.wdata[`SMD_CMD_DIR_BIT];
		end else if (pci_wr_cmd && pci_req.be[0]) begin
			d = pci_req.wdata[`SMD_CMD_DIR_BIT];
		end
		return d;
	endfunction

	function automatic logic next_pi();
		logic p;
		p = prefetch_inhibit;
		if (loc_wr_cmd && loc_req.be[0]) begin
			p = loc_req.wdata[`SMD_CMD_PI_BIT];
		end else if (pci_wr_cmd && pci_req.be[0]) begin
			p = pci_req.wdata[`SMD_CMD_PI_BIT];
		end
		return p;
	endfunction

	// move request fields come from the sequencer's flops; direction comes from the command word
	assign xfer_valid      = (state == smd_pkg::SMD_MOVE) && !soft_bit;
	assign dma_busy        = xfer_valid;
	assign xfer.dir        = dir_bit;
	assign xfer.cmd        = cur_cmd;
	assign xfer.host_addr  = {cur_host, 2'h0};
	assign xfer.local_addr = {cur_local, 2'h0};
	assign xfer.last       = (remaining == 12'h001);

	// ******************************************************************
	// read back
	// ******************************************************************

	// unmapped offsets read zero; reserved bits read zero
	function automatic logic [31:0] read_word(input logic [11:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			`SMD_OFS_LOCAL_START: w = {18'h0, local_start, 2'h0};
			`SMD_OFS_HOST_START:  w = {host_start, 2'h0};
			`SMD_OFS_LENGTH:      w = {18'h0, length, 2'h0};
			`SMD_OFS_COMMAND:     w = {22'h0, loc_own, pci_own, 6'h0,
				prefetch_inhibit, dir_bit};
			`SMD_OFS_SEMAPHORE:   w = {6'h0, sem_loc[3], sem_pci[3], 6'h0,
				sem_loc[2], sem_pci[2], 6'h0, sem_loc[1], sem_pci[1], 6'h0,
				sem_loc[0], sem_pci[0]};
			`SMD_OFS_HOST_RESET:  w = {30'h0, soft_bit, lrst_bit};
			default:              w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// data answers one cycle after the read strobe
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			loc_rdata  <= 32'h0000_0000;
			loc_rvalid <= 1'b0;
			pci_rdata  <= 32'h0000_0000;
			pci_rvalid <= 1'b0;
		end else if (ce) begin
			loc_rvalid <= loc_req.rd;
			pci_rvalid <= pci_req.rd;
			if (loc_req.rd) begin
				loc_rdata <= read_word(loc_req.addr);
			end
			if (pci_req.rd) begin
				pci_rdata <= read_word(pci_req.addr);
			end
		end
	end

	// local data bus stays off the wire while soft reset holds
	assign loc_dq_oe = loc_rvalid && !soft_bit;

endmodule

// >>> tb/smd_dma_chk_assertions.sv
// Purpose: port-level checks for the dma control block
// Assumes: one clock, async active-low reset
// Notes:   attached by bind at the foot of this file
`include "smd_cfg.svh"
module smd_dma_chk (
	input wire logic                  core_clk,
	input wire logic                  rst_b,
	input wire logic                  ce,
	input wire smd_pkg::smd_reg_req_t loc_req,
	input wire smd_pkg::smd_reg_req_t pci_req,
	input wire logic                  loc_dq_oe,
	input wire smd_pkg::smd_xfer_t    xfer,
	input wire logic                  xfer_valid,
	input wire logic                  xfer_ready,
	input wire logic                  dma_done,
	input wire logic                  soft_reset_active,
	input wire logic                  queue_flush,
	input wire logic                  mailbox_clear,
	input wire logic                  local_reset_output,
	input wire logic                  local_reset_output_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// *****
	// launch decode and properties
	// *****
	logic launch_any;
	logic hs;
	// a low-byte command write from either port may start the engine
	assign launch_any = ce && ((loc_req.wr && loc_req.addr == `SMD_OFS_COMMAND && loc_req.be[0])
		|| (pci_req.wr && pci_req.addr == `SMD_OFS_COMMAND && pci_req.be[0]));
	assign hs = ce && xfer_valid && xfer_ready;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_reset_pins: assert property (local_reset_output_b == !local_reset_output)
		else $error("reset output pair disagrees");
	a_soft_levels: assert property (queue_flush == soft_reset_active && mailbox_clear == soft_reset_active)
		else $error("flush or mailbox level differs from soft reset");
	a_soft_quiet: assert property (soft_reset_active |-> !xfer_valid && !loc_dq_oe)
		else $error("engine or data bus active in soft reset");
	a_launch_cause: assert property ($rose(xfer_valid) |-> $past(launch_any))
		else $error("transfer started without a command write");
	a_addr_step: assert property (hs && !xfer.last |=> xfer_valid
		&& xfer.local_addr == 14'($past(xfer.local_addr) + 14'h4)
		&& xfer.host_addr == $past(xfer.host_addr) + 32'h4)
		else $error("addresses did not step by one dword");
	a_done_pulse: assert property (hs && xfer.last |=> !xfer_valid && dma_done ##1 !dma_done)
		else $error("done pulse wrong after last dword");
	a_fields_hold: assert property (ce && xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer))
		else $error("dword fields moved without handshake");
	a_write_cmd: assert property (xfer_valid && xfer.dir |-> xfer.cmd == `SMD_PCI_MEM_WRITE)
		else $error("write transfer with wrong command");
	a_read_cmd: assert property (xfer_valid && !xfer.dir |-> xfer.cmd inside
		{`SMD_PCI_MEM_READ, `SMD_PCI_READ_LINE, `SMD_PCI_READ_MULT})
		else $error("read transfer with illegal command");

	c_launch: cover property ($rose(xfer_valid));
	c_last: cover property (hs && xfer.last);
	c_soft: cover property ($rose(soft_reset_active));
endmodule

bind smd_dma_ctrl smd_dma_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
	.loc_req(loc_req), .pci_req(pci_req), .loc_dq_oe(loc_dq_oe), .xfer(xfer),
	.xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .dma_done(dma_done),
	.soft_reset_active(soft_reset_active), .queue_flush(queue_flush),
	.mailbox_clear(mailbox_clear), .local_reset_output(local_reset_output),
	.local_reset_output_b(local_reset_output_b));

// >>> tb/smd_far_model.sv
// Purpose: pci master and shared memory side taking one dword per handshake
// Assumes: ready may stand high without valid
// Notes:   slow mode accepts one dword in four cycles
module smd_far_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic slow,
	output logic      xfer_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt;
	// stall pattern so the engine must hold its fields
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 2'h0;
			xfer_ready <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			xfer_ready <= !slow || cnt == 2'h3;
		end
	end
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for the dma control block
// Assumes: 250 MHz clock, reset low for 5 cycles
// Notes:   driver queues expected reads and dwords, a monitor compares
`include "smd_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  core_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  ce = 1'b1;
	logic                  auto_cfg_done = 1'b0;
	logic                  cfg_term_release = 1'b0;
	logic                  local_clear_allowed = 1'b0;
	logic                  slow = 1'b0;
	smd_pkg::smd_reg_req_t loc_req = '0;
	smd_pkg::smd_reg_req_t pci_req = '0;
	smd_pkg::smd_xfer_t    xfer;
	logic [31:0]           loc_rdata;
	logic [31:0]           pci_rdata;
	logic                  loc_rvalid, pci_rvalid, loc_dq_oe, xfer_valid, xfer_ready;
	logic                  dma_busy, dma_done, soft_reset_active, mailbox_clear, queue_flush;
	logic                  local_reset_output, local_reset_output_b;
	int                    error_cnt = 0;
	int                    tests_run = 0;
	int                    seed = 32'h80a9ee46;
	logic [31:0]           rq[$];
	smd_pkg::smd_xfer_t    xq[$];
	int                    own[5][3] = '{'{0, 'h300, 'h200}, '{1, 'h300, 'h200}, '{0, 0, 0},
		'{1, 'h100, 'h100}, '{0, 'h200, 'h100}};
	int                    lens[6] = '{1, 7, 8, 17, 20, 3};

	always #2 core_clk = ~core_clk;

	smd_dma_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .loc_req(loc_req),
		.loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid), .loc_dq_oe(loc_dq_oe), .pci_req(pci_req),
		.pci_rdata(pci_rdata), .pci_rvalid(pci_rvalid), .auto_cfg_done(auto_cfg_done),
		.cfg_term_release(cfg_term_release), .local_clear_allowed(local_clear_allowed),
		.xfer(xfer), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .dma_busy(dma_busy),
		.dma_done(dma_done), .soft_reset_active(soft_reset_active),
		.mailbox_clear(mailbox_clear), .queue_flush(queue_flush),
		.local_reset_output(local_reset_output), .local_reset_output_b(local_reset_output_b));

	smd_far_model u_far (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .xfer_ready(xfer_ready));

	// *****
	// compare and bus tasks
	// *****
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask

	// every field of the dword, command included
	task automatic chkx(input smd_pkg::smd_xfer_t e, input smd_pkg::smd_xfer_t g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected xfer exp %h got %h", e, g);
		end
	endtask

	// one access; an idle edge follows so a strobe is never set twice in a step
	task automatic acc(input bit p, input bit w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] be);
		smd_pkg::smd_reg_req_t r;
		r = '{wr: w, rd: !w, addr: a, wdata: d, be: be};
		@(posedge core_clk);
		if (p) pci_req <= r;
		else loc_req <= r;
		@(posedge core_clk);
		if (p) pci_req <= '0;
		else loc_req <= '0;
	endtask

	task automatic wr(input bit p, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		acc(p, 1'b1, a, d, be);
	endtask

	task automatic rd(input bit p, input logic [11:0] a, input logic [31:0] e);
		rq.push_back(e);
		acc(p, 1'b0, a, 32'h0, 4'hf);
	endtask

	// random setup words with junk outside the used bits, then launch
	task automatic run_xfer(input bit p, input bit dir, input bit pi, input int n);
		logic [31:0] ls, hs, ln;
		smd_pkg::smd_xfer_t e;
		int k;
		ls = $random(seed);
		hs = $random(seed);
		ln = $random(seed);
		ln[13:2] = n[11:0];
		slow <= ln[31];
		wr(p, `SMD_OFS_LOCAL_START, ls, 4'hf);
		wr(p, `SMD_OFS_HOST_START, hs, 4'hf);
		wr(p, `SMD_OFS_LENGTH, ln, 4'hf);
		for (int i = 0; i < n; i++) begin
			e.dir = dir;
			e.cmd = dir ? `SMD_PCI_MEM_WRITE : pi ? `SMD_PCI_MEM_READ
				: (n - i > 2 * `SMD_LINE_DWORDS) ? `SMD_PCI_READ_MULT
				: (n - i >= `SMD_LINE_DWORDS) ? `SMD_PCI_READ_LINE : `SMD_PCI_MEM_READ;
			e.host_addr = {hs[31:2], 2'b00} + 32'(4 * i);
			e.local_addr = {ls[13:2], 2'b00} + 14'(4 * i);
			e.last = (i == n - 1);
			xq.push_back(e);
		end
		wr(p, `SMD_OFS_COMMAND, {30'h0, pi, dir}, 4'h1);
		k = 0;
		while (dma_done !== 1'b1 && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		chk32("dwords left", 32'h0, 32'(xq.size()));
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// monitor: oldest note against each result as it appears
	always @(posedge core_clk) begin
		if (loc_rvalid === 1'b1) chk32("loc_rdata", rq.size() ? rq.pop_front() : 'x, loc_rdata);
		if (pci_rvalid === 1'b1) chk32("pci_rdata", rq.size() ? rq.pop_front() : 'x, pci_rdata);
		if (xfer_valid === 1'b1 && xfer_ready === 1'b1) chkx(xq.size() ? xq.pop_front() : 'x, xfer);
	end

	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		wrap_up();
	end

	// *****
	// main sequence
	// *****
	initial begin
		repeat (5) @(posedge core_clk);
		chk32("rst_out", 32'h1, {31'h0, local_reset_output});
		rst_b <= 1'b1;
		rd(0, `SMD_OFS_HOST_RESET, 32'h1);
		rd(1, `SMD_OFS_COMMAND, 32'h0);
		rd(0, `SMD_OFS_SEMAPHORE, 32'h0);
		rd(1, 12'h4c4, 32'h0);
		wr(1, `SMD_OFS_HOST_RESET, 32'h0, 4'h1);
		rd(1, `SMD_OFS_HOST_RESET, 32'h1);
		auto_cfg_done <= 1'b1;
		wr(0, `SMD_OFS_HOST_RESET, 32'h0, 4'h1);
		rd(0, `SMD_OFS_HOST_RESET, 32'h1);
		local_clear_allowed <= 1'b1;
		wr(0, `SMD_OFS_HOST_RESET, 32'h0, 4'h1);
		rd(0, `SMD_OFS_HOST_RESET, 32'h0);
		chk32("rst_out_b", 32'h1, {31'h0, local_reset_output_b});
		wr(1, `SMD_OFS_HOST_RESET, 32'h1, 4'h1);
		rd(1, `SMD_OFS_HOST_RESET, 32'h1);
		cfg_term_release <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(0, `SMD_OFS_HOST_RESET, 32'h0);
		cfg_term_release <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wr(own[i][0], `SMD_OFS_COMMAND, own[i][1], 4'h2);
			rd(own[i][0], `SMD_OFS_COMMAND, own[i][2]);
		end
		// every lane on, only one byte enabled, to see lane gating
		for (int n = 0; n < 4; n++) begin
			wr(1, `SMD_OFS_SEMAPHORE, 32'hffff_ffff, 4'(1 << n));
			wr(0, `SMD_OFS_SEMAPHORE, 32'hffff_ffff, 4'(1 << n));
		end
		rd(0, `SMD_OFS_SEMAPHORE, 32'h0101_0101);
		wr(1, `SMD_OFS_SEMAPHORE, 32'h0, 4'hf);
		wr(0, `SMD_OFS_SEMAPHORE, 32'h0202_0202, 4'hf);
		wr(1, `SMD_OFS_SEMAPHORE, 32'h0101_0101, 4'hf);
		rd(1, `SMD_OFS_SEMAPHORE, 32'h0202_0202);
		// enable low: a clearing write must be ignored
		@(posedge core_clk);
		ce <= 1'b0;
		wr(0, `SMD_OFS_SEMAPHORE, 32'h0, 4'hf);
		ce <= 1'b1;
		rd(0, `SMD_OFS_SEMAPHORE, 32'h0202_0202);
		for (int t = 0; t < 6; t++) run_xfer(t[0], 1'($random(seed)), 1'($random(seed)), lens[t]);
		run_xfer(0, 1'b1, 1'b1, 4);
		wr(1, `SMD_OFS_HOST_RESET, 32'h2, 4'h1);
		rd(1, `SMD_OFS_HOST_RESET, 32'h2);
		chk32("soft", 32'h1, {31'h0, soft_reset_active});
		rd(1, `SMD_OFS_COMMAND, 32'h101);
		rd(1, `SMD_OFS_LENGTH, 32'h0);
		rd(1, `SMD_OFS_SEMAPHORE, 32'h0);
		wr(1, `SMD_OFS_COMMAND, 32'h1, 4'h1);
		repeat (3) @(posedge core_clk);
		chk32("busy", 32'h0, {31'h0, dma_busy});
		wr(1, `SMD_OFS_HOST_RESET, 32'h0, 4'h1);
		rd(1, `SMD_OFS_HOST_RESET, 32'h0);
		chk32("soft", 32'h0, {31'h0, soft_reset_active});
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(0, `SMD_OFS_COMMAND, 32'h0);
		rd(0, `SMD_OFS_HOST_RESET, 32'h1);
		repeat (2) @(posedge core_clk);
		wrap_up();
	end
endmodule
